// file: clkctl_defines.svh
// Purpose: offsets, field positions, reset values and timing counts of the
//          compensated clock output control block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   register byte address is four times the register index
`ifndef CLKCTL_DEFINES_SVH
`define CLKCTL_DEFINES_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define IDX_CLK_OUT_CTL 6'h13
`define IDX_AUX_CTL 6'h14
`define IDX_STATUS 6'h15
`define ADDR_W 8

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define TCR_MSB 7
`define TCR_LSB 6
`define REFRESH_POS 5
`define COF_MSB 2
`define COF_LSB 0
`define AUX_COMP_DIS_POS 0
`define AUX_SOFT_RST_POS 1
`define TCR_RESET 2'h0
`define COF_RESET 3'h0
`define COF_HIZ 3'h7
`define COF_ONE_HZ 3'h6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_HZ 10000000
`define SEC_PER_MIN 60
`define MEAS_MIN_0 32
`define MEAS_MIN_1 16
`define MEAS_MIN_2 8
`define MEAS_MIN_3 4
`define WARMUP_S 60
`define SR_WINDOW_S 5
`define RELOAD_LIMIT_MS 100
`define FUSE_WORDS 8
`define FUSE_WORD_CYCLES 4
`define COMP_FRAC_BITS 4

`endif

// file: clkctl_pkg.sv
// Purpose: types shared by the clock output control block
// Assumes: used together with clkctl_defines.svh
// Notes:   widths are fixed
package clkctl_pkg;
   typedef logic [1:0] conv_rate_t;
   typedef logic [2:0] freq_sel_t;
   typedef enum {RL_IDLE, RL_READ, RL_DONE} reload_state_t;
endpackage : clkctl_pkg

// file: calib_reload.sv
// Purpose: copies factory calibration fuse words into shadow registers
// Assumes: fuse data answer on the same clock, valid after the word time
// Notes:   only the power-on reset touches this logic
`timescale 1ns/1ps
`include "clkctl_defines.svh"
module calib_reload import clkctl_pkg::*; #(
   parameter int RELOAD_LIMIT_CYCLES = 1000000
) (
   input logic clk,
   input logic reset,
   input logic ce,
   input logic wr_refresh,
   input logic wr_value,
   input logic [7:0] fuse_data,
   output logic [2:0] fuse_addr,
   output logic refresh_bit,
   output logic busy,
   output logic [63:0] shadow_flat
);
   reload_state_t state;
   logic [7:0] shadow [`FUSE_WORDS];
   logic [1:0] word_cnt;
   logic por_start;
   logic [19:0] busy_cycles;
   logic host_start;
   logic word_done;

   // ****************************************************************
   // start decode
   // ****************************************************************
   // a write of 1 only starts a copy when the bit reads 0 and no copy runs
   assign host_start = wr_refresh & wr_value & ~refresh_bit & (state == RL_IDLE); // [R7] [R17]
   assign word_done = (word_cnt == 2'(`FUSE_WORD_CYCLES - 1));
   assign busy = (state == RL_READ);

   // sequencer: one fuse word per word time
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= RL_IDLE;
         por_start <= 1'b1; // [R8]
         fuse_addr <= 3'h0;
         word_cnt <= 2'h0;
      end else if (ce) begin
         por_start <= 1'b0;
         case (state)
            RL_IDLE: begin
               if (por_start | host_start) begin // [R7]
                  state <= RL_READ;
                  fuse_addr <= 3'h0;
                  word_cnt <= 2'h0;
               end
            end
            RL_READ: begin
               word_cnt <= word_cnt + 2'h1;
               if (word_done) begin
                  word_cnt <= 2'h0;
                  fuse_addr <= fuse_addr + 3'h1;
                  if (fuse_addr == 3'(`FUSE_WORDS - 1)) begin
                     state <= RL_DONE;
                  end
               end
            end
            RL_DONE: state <= RL_IDLE;
            default: state <= RL_IDLE;
         endcase
      end
   end

   // completion bit: completion sets it and wins over a host clear
   always_ff @(posedge clk) begin
      if (reset) begin
         refresh_bit <= 1'b0;
      end else if (ce) begin
         if (state == RL_DONE) begin
            refresh_bit <= 1'b1; // [R8]
         end else if (wr_refresh & ~wr_value) begin
            refresh_bit <= 1'b0;
         end
      end
   end

   // shadow words, one per fuse address
   genvar gi;
   generate
      for (gi = 0; gi < `FUSE_WORDS; gi++) begin : g_shadow
         always_ff @(posedge clk) begin
            if (reset) begin
               shadow[gi] <= 8'h00;
            end else if (ce && busy && word_done && fuse_addr == 3'(gi)) begin
               shadow[gi] <= fuse_data;
            end
         end
         assign shadow_flat[gi*8 +: 8] = shadow[gi];
      end
   endgenerate

   // helper: length of the running copy
   always_ff @(posedge clk) begin
      if (reset || !busy) begin
         busy_cycles <= 20'h0_0000;
      end else if (ce) begin
         busy_cycles <= busy_cycles + 20'h0_0001;
      end
   end

   a_refresh_low_busy: assert property (@(posedge clk) disable iff (reset) // [R8]
      busy |-> !refresh_bit) else $error("refresh bit high during copy");
   a_reload_bound: assert property (@(posedge clk) disable iff (reset) // [R9]
      busy_cycles < 20'(RELOAD_LIMIT_CYCLES)) else $error("copy too long");
   a_rise_only: assert property (@(posedge clk) disable iff (reset) // [R17]
      (ce && refresh_bit && state == RL_IDLE && wr_refresh && wr_value) |=> !busy)
      else $error("copy started while bit already high");
   a_por_copy: assert property (@(posedge clk) // [R10]
      (reset ##1 (!reset && ce)) |=> busy) else $error("no copy after power-on reset");
endmodule : calib_reload

// file: clock_output_control.sv
// Purpose: temperature compensated seconds clock, periodic temperature
//          measurement, calibration reload and square-wave output control
// Assumes: OSC_IN is the raw 32.768 kHz oscillator, far slower than CLK;
//          TEMP_CORR comes from the compensation engine on CLK
// Notes:   RESET is the power-on reset; the soft reset is a register command
//
// Operation
// R1: temperature is measured right after power-on and then every 32, 16, 8 or 4 min by rate.
// R2: compensation stays inactive for the first 60 s after start-up.
// R3: compensation adds or removes single oscillator pulses ahead of the seconds divider.
// R4: the square-wave pin is fed from the uncompensated oscillator chain.
// R5: the compensated clock leaves the block only as a 1 Hz seconds pulse.
// R6: compensation can be switched off only within 5 s after a soft reset.
// R7: writing the refresh bit 0 then 1 starts a calibration copy on the rise.
// R8: the refresh bit reads 0 during any calibration copy and 1 when it is finished.
// R9: a calibration copy finishes within 100 ms.
// R10: the soft reset does not touch the calibration copy or its bit.
// R11: software should run one copy after power-up and then keep the bit at 1.
// R12: the 3-bit frequency field picks 32768 down to 1 Hz, or high impedance for 111.
// R13: the square-wave pin is push-pull, on from power-on, high impedance when off.
// R14: all selectable frequencies but 32.768 kHz have a 50:50 duty cycle.
// R15: control bit 4 should be left at 0 and unused bits read as 0.
// R16: the square-wave output is off while running from the backup battery.
// R17: writing 1 to a refresh bit that already holds 1 starts no copy.
`timescale 1ns/1ps
`include "clkctl_defines.svh"
module clock_output_control import clkctl_pkg::*; #(
   parameter int RELOAD_LIMIT_CYCLES = `RELOAD_LIMIT_MS * (`CLK_HZ / 1000)
) (
   input logic CLK,
   input logic RESET,
   input logic CE,
   input logic OSC_IN,
   input logic ON_BATTERY,
   input logic [7:0] TEMP_CORR,
   input logic [7:0] FUSE_DATA,
   output logic [2:0] FUSE_ADDR,
   output logic [63:0] CALIB_SHADOW,
   output logic SQUARE_WAVE_OUT,
   output logic SQUARE_WAVE_OE,
   output logic SEC_PULSE,
   output logic TEMP_MEAS_REQ,
   input logic [`ADDR_W-1:0] AWADDR,
   input logic AWVALID,
   output logic AWREADY,
   input logic [31:0] WDATA,
   input logic [3:0] WSTRB,
   input logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input logic BREADY,
   input logic [`ADDR_W-1:0] ARADDR,
   input logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input logic RREADY
);
   conv_rate_t temp_conversion_rate;
   freq_sel_t out_freq_select;
   logic comp_disable;
   logic [1:0] sync_a;
   logic [1:0] sync_b;
   logic osc_prev;
   logic [14:0] osc_div;
   logic [14:0] comp_cnt;
   logic [10:0] meas_cnt;
   logic first_meas;
   logic [5:0] warm_cnt;
   logic [2:0] sr_cnt;
   logic [3:0] comp_frac;
   logic [4:0] comp_pend;
   logic comp_sign;
   logic refresh_bit;
   logic reload_busy;

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   // index 0 carries the oscillator, index 1 the battery flag
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge CLK) begin
            if (RESET) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else if (CE) begin
               sync_a[gi] <= (gi == 0) ? OSC_IN : ON_BATTERY;
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // decode
   // ****************************************************************
   logic osc_s;
   logic bat_s;
   logic osc_tick;
   logic sec_tick;
   logic warm_done;
   logic comp_active;
   logic sr_window;
   logic [10:0] meas_period;
   logic [8:0] frac_sum;
   logic [15:0] comp_sum;
   logic [1:0] comp_step;
   logic [5:0] wr_idx;
   logic [5:0] rd_idx;
   logic wr_fire;
   logic rd_fire;
   logic wr_ctl;
   logic wr_aux;
   logic soft_reset;
   logic next_sqw;
   logic next_oe;

   // period of temperature measurement in seconds
   function automatic logic [10:0] meas_seconds(input conv_rate_t rate);
      case (rate)
         2'h0: meas_seconds = 11'(`MEAS_MIN_0 * `SEC_PER_MIN);
         2'h1: meas_seconds = 11'(`MEAS_MIN_1 * `SEC_PER_MIN);
         2'h2: meas_seconds = 11'(`MEAS_MIN_2 * `SEC_PER_MIN);
         default: meas_seconds = 11'(`MEAS_MIN_3 * `SEC_PER_MIN);
      endcase
   endfunction : meas_seconds

   // square-wave level for a frequency code, from the oscillator (code 0) or the free-running divider
   function automatic logic wave_level(input freq_sel_t sel, input logic osc,
                                       input logic [14:0] div);
      case (sel)
         3'h0: wave_level = osc;
         3'h1: wave_level = div[0];
         3'h2: wave_level = div[1];
         3'h3: wave_level = div[2];
         3'h4: wave_level = div[3];
         3'h5: wave_level = div[4];
         3'h6: wave_level = div[14];
         default: wave_level = 1'b0;
      endcase
   endfunction : wave_level

   // read value of a register index
   function automatic logic [31:0] reg_value(input logic [5:0] idx);
      case (idx)
         `IDX_CLK_OUT_CTL: reg_value = {24'h00_0000, temp_conversion_rate, refresh_bit,
                                        2'h0, out_freq_select}; // [R15]
         `IDX_AUX_CTL: reg_value = {31'h0000_0000, comp_disable};
         `IDX_STATUS: reg_value = {28'h000_0000, bat_s, sr_window, reload_busy,
                                   comp_active};
         default: reg_value = 32'h0000_0000;
      endcase
   endfunction : reg_value

   function automatic logic is_mapped(input logic [5:0] idx);
      is_mapped = (idx == `IDX_CLK_OUT_CTL) || (idx == `IDX_AUX_CTL) ||
                  (idx == `IDX_STATUS);
   endfunction : is_mapped

   assign osc_s = sync_b[0];
   assign bat_s = sync_b[1];
   assign osc_tick = osc_s & ~osc_prev;
   assign sec_tick = osc_tick & (osc_div == 15'h7FFF);
   assign warm_done = (warm_cnt == 6'(`WARMUP_S));
   assign comp_active = warm_done & ~comp_disable; // [R2]
   assign sr_window = (sr_cnt != 3'(`SR_WINDOW_S));
   assign meas_period = meas_seconds(temp_conversion_rate);
   assign frac_sum = {1'b0, comp_frac} + {1'b0, (TEMP_CORR[7] ? -TEMP_CORR : TEMP_CORR)};
   // a pending pulse adds a second count or swallows one
   assign comp_step = (comp_pend == 5'h00) ? 2'h1 : (comp_sign ? 2'h0 : 2'h2); // [R3]
   assign comp_sum = {1'b0, comp_cnt} + {14'h0000, comp_step};
   assign wr_idx = AWADDR[7:2];
   assign rd_idx = ARADDR[7:2];
   assign wr_fire = AWREADY & AWVALID & WVALID;
   assign rd_fire = ARREADY & ARVALID;
   assign wr_ctl = wr_fire & WSTRB[0] & (wr_idx == `IDX_CLK_OUT_CTL);
   assign wr_aux = wr_fire & WSTRB[0] & (wr_idx == `IDX_AUX_CTL);
   assign soft_reset = wr_aux & WDATA[`AUX_SOFT_RST_POS];
   assign next_sqw = wave_level(out_freq_select, osc_s, osc_div); // [R4] [R12] [R14]
   assign next_oe = (out_freq_select != `COF_HIZ) & ~bat_s; // [R12] [R13] [R16]

   // ****************************************************************
   // oscillator chains
   // ****************************************************************
   // uncompensated divider, feeds the square wave and the second count
   always_ff @(posedge CLK) begin
      if (RESET) begin
         osc_prev <= 1'b0;
         osc_div <= 15'h0000;
      end else if (CE) begin
         osc_prev <= osc_s;
         if (osc_tick) begin
            osc_div <= osc_div + 15'h0001; // [R4]
         end
      end
   end

   // compensated prescaler, whose carry is the seconds pulse
   always_ff @(posedge CLK) begin
      if (RESET) begin
         comp_cnt <= 15'h0000;
         SEC_PULSE <= 1'b0;
      end else if (CE) begin
         SEC_PULSE <= osc_tick & comp_sum[15]; // [R5]
         if (osc_tick) begin
            comp_cnt <= comp_sum[14:0]; // [R3]
         end
      end
   end

   // correction spread: a fraction per second, whole pulses one per tick
   always_ff @(posedge CLK) begin
      if (RESET) begin
         comp_frac <= 4'h0;
         comp_pend <= 5'h00;
         comp_sign <= 1'b0;
      end else if (CE) begin
         if (sec_tick && comp_active) begin
            comp_frac <= frac_sum[3:0];
            comp_pend <= comp_pend + frac_sum[8:4] - {4'h0, osc_tick && comp_pend != 5'h00};
            comp_sign <= TEMP_CORR[7]; // [R3]
         end else if (!comp_active) begin
            comp_frac <= 4'h0;
            comp_pend <= 5'h00; // [R2]
         end else if (osc_tick && comp_pend != 5'h00) begin
            comp_pend <= comp_pend - 5'h01;
         end
      end
   end

   // ****************************************************************
   // measurement, warm-up and soft reset window
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         first_meas <= 1'b1;
         meas_cnt <= 11'h000;
         TEMP_MEAS_REQ <= 1'b0;
      end else if (CE) begin
         first_meas <= 1'b0;
         TEMP_MEAS_REQ <= first_meas; // [R1]
         if (sec_tick) begin
            meas_cnt <= meas_cnt + 11'h001;
            if (meas_cnt >= meas_period - 11'h001) begin
               meas_cnt <= 11'h000;
               TEMP_MEAS_REQ <= 1'b1; // [R1]
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         warm_cnt <= 6'h00;
         sr_cnt <= 3'(`SR_WINDOW_S);
      end else if (CE) begin
         if (sec_tick && !warm_done) begin
            warm_cnt <= warm_cnt + 6'h01; // [R2]
         end
         if (soft_reset) begin
            sr_cnt <= 3'h0; // [R6]
         end else if (sec_tick && sr_window) begin
            sr_cnt <= sr_cnt + 3'h1;
         end
      end
   end

   // ****************************************************************
   // control register
   // ****************************************************************
   // the soft reset returns the fields to defaults but leaves calibration alone
   always_ff @(posedge CLK) begin
      if (RESET) begin
         temp_conversion_rate <= `TCR_RESET;
         out_freq_select <= `COF_RESET;
         comp_disable <= 1'b0;
      end else if (CE) begin
         if (soft_reset) begin
            temp_conversion_rate <= `TCR_RESET;
            out_freq_select <= `COF_RESET;
            comp_disable <= 1'b0;
         end else begin
            if (wr_ctl) begin
               temp_conversion_rate <= WDATA[`TCR_MSB:`TCR_LSB];
               out_freq_select <= WDATA[`COF_MSB:`COF_LSB];
            end
            if (wr_aux && (sr_window || !WDATA[`AUX_COMP_DIS_POS])) begin
               comp_disable <= WDATA[`AUX_COMP_DIS_POS]; // [R6]
            end
         end
      end
   end

   calib_reload #(
      .RELOAD_LIMIT_CYCLES(RELOAD_LIMIT_CYCLES)
   ) u_reload (
      .clk(CLK),
      .reset(RESET), // [R10]
      .ce(CE),
      .wr_refresh(wr_ctl),
      .wr_value(WDATA[`REFRESH_POS]),
      .fuse_data(FUSE_DATA),
      .fuse_addr(FUSE_ADDR),
      .refresh_bit(refresh_bit),
      .busy(reload_busy),
      .shadow_flat(CALIB_SHADOW)
   );

   // ****************************************************************
   // square-wave pin and register bus
   // ****************************************************************
   always_ff @(posedge CLK) begin
      if (RESET) begin
         SQUARE_WAVE_OUT <= 1'b0;
         SQUARE_WAVE_OE <= 1'b1; // [R13]
      end else if (CE) begin
         SQUARE_WAVE_OUT <= next_sqw & next_oe;
         SQUARE_WAVE_OE <= next_oe;
      end
   end

   // ready pulses for one cycle, then the answer stands until taken
   always_ff @(posedge CLK) begin
      if (RESET) begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= `RESP_OKAY;
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RRESP <= `RESP_OKAY;
         RDATA <= 32'h0000_0000;
      end else if (CE) begin
         AWREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
         WREADY <= AWVALID & WVALID & ~AWREADY & ~BVALID;
         ARREADY <= ARVALID & ~ARREADY & ~RVALID;
         if (wr_fire) begin
            BVALID <= 1'b1;
            BRESP <= is_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (BREADY) begin
            BVALID <= 1'b0;
         end
         if (rd_fire) begin
            RVALID <= 1'b1;
            RDATA <= reg_value(rd_idx);
            RRESP <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   a_hiz_code: assert property (@(posedge CLK) disable iff (RESET) // [R12]
      (CE && out_freq_select == `COF_HIZ) |=> !SQUARE_WAVE_OE) else $error("pin driven at 111");
   a_battery_off: assert property (@(posedge CLK) disable iff (RESET) // [R16]
      (CE && bat_s) |=> (!SQUARE_WAVE_OE && !SQUARE_WAVE_OUT)) else $error("pin on battery");
   a_warmup_hold: assert property (@(posedge CLK) disable iff (RESET) // [R2]
      (warm_cnt < 6'(`WARMUP_S)) |-> (comp_pend == 5'h00 && !comp_active))
      else $error("compensation before warm-up");
   a_window_reject: assert property (@(posedge CLK) disable iff (RESET) // [R6]
      (CE && !sr_window && !comp_disable && !soft_reset) |=> !comp_disable)
      else $error("disable taken outside window");
   a_sec_from_tick: assert property (@(posedge CLK) disable iff (RESET) // [R5]
      SEC_PULSE |-> $past(osc_tick)) else $error("seconds pulse without oscillator edge");
   a_onehz_wave: assert property (@(posedge CLK) disable iff (RESET) // [R4]
      (CE && out_freq_select == `COF_ONE_HZ && next_oe) |=> SQUARE_WAVE_OUT == $past(osc_div[14]))
      else $error("1 Hz wave not from free divider");
   a_meas_cause: assert property (@(posedge CLK) disable iff (RESET) // [R1]
      TEMP_MEAS_REQ |-> ($past(first_meas) || $past(sec_tick) || !$past(CE)))
      else $error("stray measurement");
endmodule : clock_output_control

// file: clock_output_control_tb.sv
// Purpose: self-checking bench of the clock output control block
// Assumes: bench drives the register bus, oscillator and fuse data itself
// Notes:   oscillator runs at one eighth of CLK to keep the run short
`timescale 1ns/1ps
`include "clkctl_defines.svh"
module compensated_clock_output_control_tb import clkctl_pkg::*; ;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic CLK = 0, RESET = 1, CE = 1, OSC_IN = 0, ON_BATTERY = 0;
   logic [7:0] TEMP_CORR = 8'h10, FUSE_DATA = 8'h00, AWADDR = 8'h00, ARADDR = 8'h00;
   logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic [31:0] WDATA = 32'h0000_0000;
   logic [3:0] WSTRB = 4'hF;
   logic [2:0] FUSE_ADDR;
   logic [63:0] CALIB_SHADOW;
   logic SQUARE_WAVE_OUT, SQUARE_WAVE_OE, SEC_PULSE, TEMP_MEAS_REQ;
   logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [1:0] BRESP, RRESP;
   logic [31:0] RDATA;
   logic [3:0] osc_cnt = 4'h0;
   int err_total = 0, num_checks = 0;
   localparam logic [7:0] ctl_addr = {`IDX_CLK_OUT_CTL, 2'h0};
   localparam logic [7:0] aux_addr = {`IDX_AUX_CTL, 2'h0};
   localparam logic [7:0] stat_addr = {`IDX_STATUS, 2'h0};
   localparam logic [7:0] bad_addr = 8'h58;
   typedef struct {logic [7:0] wr; logic [7:0] rd; logic oe;} row_t;
   // written value, read-back value, expected pin enable
   row_t rows[5] = '{'{8'hE5, 8'hE5, 1'h1}, '{8'h6F, 8'h67, 1'h0}, '{8'hA1, 8'hA1, 1'h1},
      '{8'h2E, 8'h26, 1'h1}, '{8'h27, 8'h27, 1'h0}};

   clock_output_control #(.RELOAD_LIMIT_CYCLES(100)) clock_output_control_i (.CLK, .RESET, .CE, .OSC_IN,
      .ON_BATTERY, .TEMP_CORR, .FUSE_DATA, .FUSE_ADDR, .CALIB_SHADOW, .SQUARE_WAVE_OUT,
      .SQUARE_WAVE_OE, .SEC_PULSE, .TEMP_MEAS_REQ, .AWADDR, .AWVALID, .AWREADY, .WDATA,
      .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
      .RDATA, .RRESP, .RVALID, .RREADY);

   // clock, oscillator and fuse array answering one cycle after the address
   always #50 CLK = ~CLK;
   always @(posedge CLK) begin
      osc_cnt <= osc_cnt + 4'h1;
      OSC_IN <= osc_cnt[2];
      FUSE_DATA <= {5'h15, FUSE_ADDR};
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // bus write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw, w;
      aw = 0;
      w = 0;
      r = 2'h3;
      @(posedge CLK);
      AWADDR <= a;
      WDATA <= d;
      AWVALID <= 1'h1;
      WVALID <= 1'h1;
      BREADY <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge CLK);
         if (aw && w && BVALID) begin
            r = BRESP;
            BREADY <= 1'h0;
            break;
         end
         if (AWREADY) begin
            aw = 1;
            AWVALID <= 1'h0;
         end
         if (WREADY) begin
            w = 1;
            WVALID <= 1'h0;
         end
      end
      if (n == 100) begin
         err_total++;
         wrap_up();
      end
   endtask : wr

   // bus read: ready held until the data is taken
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar;
      ar = 0;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'h1;
      RREADY <= 1'h1;
      for (n = 0; n < 100; n++) begin
         @(posedge CLK);
         if (ar && RVALID) begin
            d = RDATA;
            r = RRESP;
            RREADY <= 1'h0;
            break;
         end
         if (ARREADY) begin
            ar = 1;
            ARVALID <= 1'h0;
         end
      end
      if (n == 100) begin
         err_total++;
         wrap_up();
      end
   endtask : rd

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int rq, hi, ri;
      logic p;
      repeat (3) @(posedge CLK);
      RESET <= 1'h0;
      rq = 0;
      repeat (20) begin
         @(posedge CLK);
         rq += TEMP_MEAS_REQ;
      end
      chk("meas_req", rq, 1);
      rd(ctl_addr, d, r);
      chk("ctl_por", d, 32'h0000_0000);
      chk("oe_por", SQUARE_WAVE_OE, 1'h1);
      repeat (100) @(posedge CLK);
      rd(ctl_addr, d, r);
      chk("ctl_done", d, 32'h0000_0020);
      chk("shadow", CALIB_SHADOW, 64'hAFAE_ADAC_ABAA_A9A8);
      // disable refused while no soft reset window is open
      wr(aux_addr, 32'h0000_0001, r);
      rd(aux_addr, d, r);
      chk("dis_refused", d, 32'h0000_0000);
      // table of control values
      foreach (rows[i]) begin
         wr(ctl_addr, {24'h00_0000, rows[i].wr}, r);
         rd(ctl_addr, d, r);
         chk("ctl_row", d, {24'h00_0000, rows[i].rd});
         chk("oe_row", SQUARE_WAVE_OE, rows[i].oe);
         if (!rows[i].oe)
            chk("out_off", SQUARE_WAVE_OUT, 1'h0);
      end
      // edge count and high time over 64 oscillator periods per code
      for (int c = 0; c < 6; c++) begin
         wr(ctl_addr, 32'h0000_0020 + c, r);
         repeat (8) @(posedge CLK);
         ri = 0;
         hi = 0;
         p = SQUARE_WAVE_OUT;
         repeat (512) begin
            @(posedge CLK);
            ri += (SQUARE_WAVE_OUT && !p);
            hi += SQUARE_WAVE_OUT;
            p = SQUARE_WAVE_OUT;
         end
         chk("sq_rise", (ri - (64 >> c)) inside {[-1:1]}, 1'h1);
         if (c > 0)
            chk("sq_duty", hi, 256);
      end
      // refresh handshake, soft reset during a copy
      wr(ctl_addr, 32'h0000_0020, r);
      rd(ctl_addr, d, r);
      chk("no_restart", d, 32'h0000_0020);
      wr(ctl_addr, 32'h0000_0000, r);
      wr(ctl_addr, 32'h0000_0023, r);
      rd(ctl_addr, d, r);
      chk("copy_busy", d, 32'h0000_0003);
      rd(stat_addr, d, r);
      chk("stat_busy", d[1:0], 2'h2);
      wr(aux_addr, 32'h0000_0002, r);
      rd(ctl_addr, d, r);
      chk("sr_ctl", d, 32'h0000_0000);
      repeat (100) @(posedge CLK);
      rd(ctl_addr, d, r);
      chk("sr_copy", d, 32'h0000_0020);
      wr(aux_addr, 32'h0000_0001, r);
      rd(aux_addr, d, r);
      chk("comp_dis", d, 32'h0000_0001);
      // unmapped place
      rd(bad_addr, d, r);
      chk("bad_rd", {r, d}, {`RESP_SLVERR, 32'h0000_0000});
      wr(bad_addr, 32'h0000_00FF, r);
      chk("bad_wr", r, `RESP_SLVERR);
      // clock enable low freezes the pin while the oscillator runs
      CE <= 1'h0;
      @(posedge CLK);
      p = SQUARE_WAVE_OUT;
      ri = 0;
      repeat (20) begin
         @(posedge CLK);
         ri += (SQUARE_WAVE_OUT != p);
      end
      chk("ce_hold", ri, 0);
      CE <= 1'h1;
      // backup battery turns the pin off
      ON_BATTERY <= 1'h1;
      repeat (6) @(posedge CLK);
      chk("bat_oe", SQUARE_WAVE_OE, 1'h0);
      ON_BATTERY <= 1'h0;
      repeat (6) @(posedge CLK);
      chk("bat_off", SQUARE_WAVE_OE, 1'h1);
      // less than one second has passed, so no seconds pulse yet
      chk("sec_idle", SEC_PULSE, 1'h0);
      wrap_up();
   end
endmodule : compensated_clock_output_control_tb
